// *** bench/field_bridge_model.sv ***
// behavioural field bridge and winding driven by the firing angle
`timescale 1ns/100ps
module field_bridge_model (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire field_opts_pkg::value_type firing_angle,
  input  wire logic                      bridge_full_control,
  output field_opts_pkg::value_type      field_current
);
  import field_opts_pkg::*;
  int level_r;
  int level_nxt;
  // half control reaches only half the voltage; the winding lags it
  assign level_nxt = bridge_full_control ? 8 * firing_angle : 4 * firing_angle;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      level_r <= 0;
    else
      level_r <= level_r + (level_nxt - level_r) / 16;
  end
  assign field_current = value_type'(level_r / 8);
endmodule

// *** bench/field_opts_props.sv ***
// port level properties of the field option block
`timescale 1ns/100ps
module field_opts_props (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      bridge_mode_link,
  input wire field_opts_pkg::value_type field_loop_angle,
  input wire field_opts_pkg::value_type field_current_demand,
  input wire field_opts_pkg::value_type firing_angle,
  input wire logic                      volt_igain_doubled,
  input wire logic                      ir_comp_from_current,
  input wire logic                      bridge_full_control,
  input wire logic [1:0]                field_gain_shift,
  input wire logic                      loops_bypassed,
  input wire logic [15:0]               speed_gain_factor
);
  import field_opts_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_FIRE_MAX: assert property (firing_angle <= 10'h3e8)
    else $error("firing angle beyond full advance");
  AST_DEMAND_MAX: assert property (field_current_demand <= 10'h3e8)
    else $error("field demand beyond full scale");
  AST_FIRE_CLAMP: assert property (!loops_bypassed |->
    firing_angle <= $past(field_loop_angle))
    else $error("firing angle above loop angle");
  AST_BRIDGE: assert property (bridge_full_control |->
    $past(bridge_mode_link))
    else $error("full control without link");
  AST_CFG_STILL: assert property ($changed({volt_igain_doubled,
    ir_comp_from_current, loops_bypassed, field_gain_shift}) |->
    $past(s_axi_wready) || $past(s_axi_wready, 2) || $past(s_axi_wready, 3))
    else $error("option output moved without a write");
  AST_SGF_RST: assert property ($rose(aresetn) |->
    speed_gain_factor == 16'h0400)
    else $error("speed gain factor not unity after reset");
  AST_READ_ANS: assert property (s_axi_arvalid && !s_axi_rvalid &&
    !s_axi_arready |=> s_axi_rvalid && s_axi_arready)
    else $error("read not answered in one cycle");
  AST_WRITE_ANS: assert property (s_axi_awready && s_axi_wready |=>
    s_axi_bvalid)
    else $error("write response missing");
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
  cover property (loops_bypassed);
  cover property (bridge_full_control);
  cover property (field_gain_shift == 2'h3);
endmodule

bind field_economy_and_loop_options field_opts_props props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .bridge_mode_link(bridge_mode_link),
  .field_loop_angle(field_loop_angle), .firing_angle(firing_angle),
  .field_current_demand(field_current_demand),
  .volt_igain_doubled(volt_igain_doubled), .loops_bypassed(loops_bypassed),
  .ir_comp_from_current(ir_comp_from_current),
  .bridge_full_control(bridge_full_control),
  .field_gain_shift(field_gain_shift), .speed_gain_factor(speed_gain_factor));

// *** bench/test_field_economy_and_loop_options.sv ***
// self-checking bench of the field option block
`timescale 1ns/100ps
`include "field_opts_regs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module test_field_economy_and_loop_options;
  import field_opts_pkg::*;
  logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        drive_enable, bridge_mode_link, second_max_active, lnk;
  logic        field_igain_increased, volt_igain_doubled, loops_bypassed;
  logic        ir_comp_from_current, bridge_full_control;
  logic [1:0]  s_axi_bresp, s_axi_rresp, field_gain_shift, resp;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  flg;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] speed_gain_factor;
  word_type    s_axi_wdata, s_axi_rdata, rd;
  value_type   emf_loop_demand, field_loop_angle, field_current_demand;
  value_type   firing_angle, field_current;
  int          fail_count, n_tests, seed, ctl, stop, mx1, mx2, mn, emf, ang;
  int          dem, ceil, src;
  logic [7:0]  ofs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  int          rv[7] = '{'h1e, 'h8, 'h3e8, 'h3e8, 'h1f4, 'h1f4, 'h65};

  field_economy_and_loop_options dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .drive_enable(drive_enable), .bridge_mode_link(bridge_mode_link),
    .emf_loop_demand(emf_loop_demand), .field_loop_angle(field_loop_angle),
    .field_current_demand(field_current_demand),
    .firing_angle(firing_angle), .second_max_active(second_max_active),
    .field_igain_increased(field_igain_increased),
    .volt_igain_doubled(volt_igain_doubled),
    .ir_comp_from_current(ir_comp_from_current),
    .bridge_full_control(bridge_full_control),
    .field_gain_shift(field_gain_shift), .loops_bypassed(loops_bypassed),
    .speed_gain_factor(speed_gain_factor));
  field_bridge_model bridge (.aclk(aclk), .aresetn(aresetn),
    .firing_angle(firing_angle), .bridge_full_control(bridge_full_control),
    .field_current(field_current));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7fffffff) % n;
  endfunction

  task automatic wr(input logic [7:0] a, input int d);
    bit aw;
    bit w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    complete_run;
  end

  initial begin
    {fail_count, n_tests, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, bridge_mode_link, emf_loop_demand, field_loop_angle} = '0;
    seed = 89;
    clk_en = 1'b1;
    aresetn = 1'b0;
    drive_enable = 1'b1;
    s_axi_wstrb = 4'hf;
    settle(16);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdr(ofs[i]);
      `CHK(rd, rv[i])
    end
    `CHK(field_igain_increased, 1'b0)
    rdr(8'h40);
    `CHK(resp, `AXI_SLVERR)
    wr(`FIRING_OFS, 5);
    `CHK(resp, `AXI_SLVERR)
    wr(`FB_SCALING_OFS, 'h6e);
    wr(`FB_SCALING_OFS, 'h6f);
    wr(`FB_SCALING_OFS, 'h64);
    rdr(`FB_SCALING_OFS);
    `CHK(rd, 'h6e)
    wr(`ENDSTOP_OFS, 'h3ff);
    rdr(`ENDSTOP_OFS);
    `CHK(rd, 'h3e8)
    repeat (24) begin
      ctl = rnd(1024) & 'h3fb;
      mn = 100 + rnd(400);
      mx1 = mn + rnd(1001 - mn);
      mx2 = mn + rnd(1001 - mn);
      stop = rnd(1001);
      emf = rnd(1001);
      ang = rnd(1024);
      lnk = rnd(2);
      wr(`CONTROL_OFS, ctl);
      wr(`ENDSTOP_OFS, stop);
      wr(`MAX_FIELD_1_OFS, mx1);
      wr(`MAX_FIELD_2_OFS, mx2);
      wr(`MIN_FIELD_OFS, mn);
      bridge_mode_link <= lnk;
      emf_loop_demand <= value_type'(emf);
      field_loop_angle <= value_type'(ang);
      settle(6);
      ceil = ctl[1] ? mx2 : mx1;
      dem = emf < mn ? mn : (emf > ceil ? ceil : emf);
      src = ctl[5] ? mx2 : ang;
      flg = {ctl[5], ctl[6], ctl[4], !ctl[3], ctl[1]};
      `CHK(field_current_demand, dem)
      `CHK(firing_angle, src > stop ? stop : src)
      `CHK(speed_gain_factor, ctl[0] ? mx1 * 1024 / dem : 1024)
      `CHK({loops_bypassed, ir_comp_from_current, volt_igain_doubled, 
        field_igain_increased, second_max_active}, flg)
      `CHK(bridge_full_control, ctl[7] & lnk)
      `CHK(field_gain_shift, ctl[9:8])
      rdr(`CONTROL_OFS);
      `CHK(rd, ctl)
    end
    // clock enable low freezes the registered demand
    emf = emf < 500 ? 900 : 100;
    src = emf < mn ? mn : (emf > ceil ? ceil : emf);
    clk_en <= 1'b0;
    emf_loop_demand <= value_type'(emf);
    settle(4);
    `CHK(field_current_demand, dem)
    clk_en <= 1'b1;
    settle(2);
    `CHK(field_current_demand, src)
    // lane 1 disabled: only bits 7:0 are written, the gain reduction bits keep their value
    s_axi_wstrb <= 4'h1;
    wr(`CONTROL_OFS, 'h300);
    s_axi_wstrb <= 4'hf;
    rdr(`CONTROL_OFS);
    `CHK(rd, ctl & 'h300)
    wr(`ECON_TIMEOUT_OFS, 0);
    wr(`CONTROL_OFS, 'h6);
    settle(6);
    `CHK(second_max_active, 1'b0)
    drive_enable <= 1'b0;
    settle(8);
    `CHK(second_max_active, 1'b1)
    drive_enable <= 1'b1;
    settle(8);
    `CHK(second_max_active, 1'b0)
    wr(`ECON_TIMEOUT_OFS, 1);
    drive_enable <= 1'b0;
    settle(100);
    `CHK(second_max_active, 1'b0)
    drive_enable <= 1'b1;
    settle(2);
    complete_run;
  end
endmodule

// *** hdl/field_economy_and_loop_options.sv ***
// field economy timer, loop option bits and firing angle limiting
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "field_opts_regs.svh"

module field_economy_and_loop_options (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       clk_en,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       drive_enable,
  input  wire logic                       bridge_mode_link,
  input  wire field_opts_pkg::value_type  emf_loop_demand,
  input  wire field_opts_pkg::value_type  field_loop_angle,
  output field_opts_pkg::value_type       field_current_demand,
  output field_opts_pkg::value_type       firing_angle,
  output logic                            second_max_active,
  output logic                            field_igain_increased,
  output logic                            volt_igain_doubled,
  output logic                            ir_comp_from_current,
  output logic                            bridge_full_control,
  output logic [1:0]                      field_gain_shift,
  output logic                            loops_bypassed,
  output logic [15:0]                     speed_gain_factor
);
  import field_opts_pkg::*;

  logic [7:0]     econ_timeout_r;
  logic [9:0]     ctl_r;
  value_type      endstop_r;
  value_type      max_field_1_r;
  value_type      max_field_2_r;
  value_type      min_field_r;
  logic [7:0]     fb_scaling_r;
  econ_state_type econ_state_r;
  econ_state_type econ_state_nxt;
  logic [25:0]    sec_cnt_r;
  logic [7:0]     secs_r;
  logic           drive_enable_r;
  logic [7:0]     aw_addr_r;
  logic           aw_held_r;
  logic [31:0]    w_data_r;
  logic [3:0]     w_strb_r;
  logic           w_held_r;
  logic           wr_fire;
  logic           wr_known;
  logic           rd_known;
  logic [31:0]    rd_word;
  value_type      ceiling;
  value_type      demand_lim;
  value_type      angle_src;
  logic           auto_select;
  logic [19:0]    gain_quot;

  // limit a value between a low and a high bound
  function automatic value_type clamp(input value_type v, input value_type lo,
                                      input value_type hi);
    if (v > hi) begin
      return hi;
    end else if (v < lo) begin
      return lo;
    end
    return v;
  endfunction

  // registers that accept writes
  function automatic logic is_writable(input logic [7:0] a);
    case (a)
      `ECON_TIMEOUT_OFS, `CONTROL_OFS, `ENDSTOP_OFS, `MAX_FIELD_1_OFS,
      `MAX_FIELD_2_OFS, `MIN_FIELD_OFS, `FB_SCALING_OFS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // write channel: address and data may come in either order
  // a write lands only once the previous response has been accepted
  assign wr_fire  = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_known = is_writable(aw_addr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      if (s_axi_awvalid && !aw_held_r && !s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b1;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= 1'b0;
      if (s_axi_wvalid && !w_held_r && !s_axi_wready) begin
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b1;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // settings written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      econ_timeout_r <= `ECON_TIMEOUT_RST;
      endstop_r      <= `ENDSTOP_RST;
      max_field_1_r  <= `MAX_FIELD_1_RST;
      max_field_2_r  <= `MAX_FIELD_2_RST;
      min_field_r    <= `MIN_FIELD_RST;
      fb_scaling_r   <= `FB_SCALING_RST;
    end else if (clk_en && wr_fire) begin
      case (aw_addr_r)
        `ECON_TIMEOUT_OFS: if (w_strb_r[0]) econ_timeout_r <= w_data_r[7:0];
        `ENDSTOP_OFS: if (w_strb_r[0]) endstop_r <= clamp(w_data_r[9:0],
                                          10'h000, `FIRING_FULL);
        `MAX_FIELD_1_OFS: if (w_strb_r[0]) max_field_1_r <= clamp(
                                          w_data_r[9:0], 10'h000, `FIRING_FULL);
        `MAX_FIELD_2_OFS: if (w_strb_r[0]) max_field_2_r <= clamp(
                                          w_data_r[9:0], 10'h000, `FIRING_FULL);
        `MIN_FIELD_OFS: if (w_strb_r[0]) min_field_r <= clamp(
                                          w_data_r[9:0], 10'h000, `FIRING_FULL);
        `FB_SCALING_OFS: begin
          // out of range codes are ignored
          if (w_strb_r[0] && w_data_r[7:0] >= `FB_SCALING_MIN &&
              w_data_r[7:0] <= `FB_SCALING_MAX) begin
            fb_scaling_r <= w_data_r[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // control bits; the select bit follows the timer while economy is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= `CTL_RST;
    end else if (clk_en) begin
      if (wr_fire && aw_addr_r == `CONTROL_OFS) begin
        if (w_strb_r[0]) begin
          ctl_r[7:0] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          ctl_r[9:8] <= w_data_r[9:8];
        end
      end
      if (auto_select) begin
        ctl_r[`CTL_SECOND_MAX] <= econ_state_r == econ_reduced;
      end
    end
  end

  assign auto_select = ctl_r[`CTL_ECON_EN];

  // economy timer
  always_comb begin
    econ_state_nxt = econ_state_r;
    case (econ_state_r)
      econ_idle: begin
        if (ctl_r[`CTL_ECON_EN] && !drive_enable) begin
          econ_state_nxt = econ_timing;
        end
      end
      econ_timing: begin
        if (!ctl_r[`CTL_ECON_EN] || drive_enable) begin
          econ_state_nxt = econ_idle;
        end else if (secs_r >= econ_timeout_r) begin
          econ_state_nxt = econ_reduced;
        end
      end
      econ_reduced: begin
        if (!ctl_r[`CTL_ECON_EN] || drive_enable) begin
          econ_state_nxt = econ_idle;
        end
      end
      default: econ_state_nxt = econ_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      econ_state_r   <= econ_idle;
      drive_enable_r <= 1'b0;
    end else if (clk_en) begin
      econ_state_r   <= econ_state_nxt;
      drive_enable_r <= drive_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_r <= 26'h0;
      secs_r    <= 8'h00;
    end else if (clk_en) begin
      if (econ_state_r != econ_timing) begin
        sec_cnt_r <= 26'h0;
        secs_r    <= 8'h00;
      end else if (sec_cnt_r == 26'(`SEC_CYCLES - 1)) begin
        sec_cnt_r <= 26'h0;
        if (secs_r != 8'hff) begin
          secs_r <= secs_r + 8'h01;
        end
      end else begin
        sec_cnt_r <= sec_cnt_r + 26'h1;
      end
    end
  end

  // field current ceiling and demand limiting
  assign ceiling = ctl_r[`CTL_SECOND_MAX] ? max_field_2_r
                                          : max_field_1_r;
  assign demand_lim = clamp(emf_loop_demand, min_field_r, ceiling);
  // direct mode: max field 2 becomes the angle, endstop is the sole limit
  assign angle_src = ctl_r[`CTL_DIRECT_FIRE] ? max_field_2_r
                                             : field_loop_angle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_current_demand <= 10'h000;
      firing_angle         <= 10'h000;
      second_max_active    <= 1'b0;
      loops_bypassed       <= 1'b0;
    end else if (clk_en) begin
      field_current_demand <= demand_lim;
      // larger value means more advance, full forward at 1000
      firing_angle <= clamp(angle_src, 10'h000, endstop_r);
      second_max_active <= ctl_r[`CTL_SECOND_MAX];
      loops_bypassed    <= ctl_r[`CTL_DIRECT_FIRE];
    end
  end

  // loop option outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_igain_increased <= 1'b0;
      volt_igain_doubled    <= 1'b0;
      ir_comp_from_current  <= 1'b0;
      bridge_full_control   <= 1'b0;
      field_gain_shift      <= 2'h0;
    end else if (clk_en) begin
      field_igain_increased <= !ctl_r[`CTL_FIELD_IGAIN];
      volt_igain_doubled    <= ctl_r[`CTL_VOLT_IGAIN];
      ir_comp_from_current  <= ctl_r[`CTL_IR_SRC];
      // full control needs the link in its full position too
      bridge_full_control <= ctl_r[`CTL_BRIDGE_FULL] &&
                             bridge_mode_link;
      // both bits: shifts add, divide by 8
      field_gain_shift <= {1'b0, ctl_r[`CTL_REDUCE_TWO]} +
                          {ctl_r[`CTL_REDUCE_FOUR], 1'b0};
    end
  end

  // quotient leaves 16 bits only for very small demands; it saturates then
  assign gain_quot = ({10'h000, max_field_1_r} << `GAIN_FRAC_BITS) /
                     {10'h000, demand_lim};

  // speed gain factor, unsigned 6.10 fixed point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_gain_factor <= `GAIN_UNITY;
    end else if (clk_en) begin
      if (!ctl_r[`CTL_FIELD_EN] || demand_lim == 10'h000) begin
        speed_gain_factor <= `GAIN_UNITY;
      end else if (gain_quot > 20'h0ffff) begin
        speed_gain_factor <= 16'hffff;
      end else begin
        speed_gain_factor <= gain_quot[15:0];
      end
    end
  end

  // read channel
  always_comb begin
    rd_known = 1'b1;
    rd_word  = 32'h0000_0000;
    case (s_axi_araddr)
      `ECON_TIMEOUT_OFS:    rd_word = {24'h0, econ_timeout_r};
      `CONTROL_OFS:         rd_word = {22'h0, ctl_r};
      `ENDSTOP_OFS:         rd_word = {22'h0, endstop_r};
      `MAX_FIELD_1_OFS:     rd_word = {22'h0, max_field_1_r};
      `MAX_FIELD_2_OFS:     rd_word = {22'h0, max_field_2_r};
      `MIN_FIELD_OFS:       rd_word = {22'h0, min_field_r};
      `FIELD_DEMAND_IN_OFS: rd_word = {22'h0, emf_loop_demand};
      `FB_SCALING_OFS:      rd_word = {24'h0, fb_scaling_r};
      `STATUS_OFS:          rd_word = {20'h0, secs_r, econ_state_r,
                                       drive_enable_r};
      `FIRING_OFS:          rd_word = {22'h0, firing_angle};
      `FIELD_DEMAND_OFS:    rd_word = {22'h0, field_current_demand};
      `GAIN_CODE_OFS:       rd_word = {16'h0, speed_gain_factor};
      default:              rd_known = 1'b0;
    endcase
  end

  // read data is captured in the cycle the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** hdl/field_opts_pkg.sv ***
// types shared by the field option block
package field_opts_pkg;
  typedef logic [9:0]  value_type;
  typedef logic [31:0] word_type;
  typedef enum logic [2:0] {
    econ_idle    = 3'b001,
    econ_timing  = 3'b010,
    econ_reduced = 3'b100
  } econ_state_type;
endpackage

// *** hdl/field_opts_regs.svh ***
// register offsets, reset values and timing constants of the field option block
`ifndef FIELD_OPTS_REGS_SVH
`define FIELD_OPTS_REGS_SVH

`define ECON_TIMEOUT_OFS     8'h00
`define CONTROL_OFS          8'h04
`define ENDSTOP_OFS          8'h08
`define MAX_FIELD_1_OFS      8'h0c
`define MAX_FIELD_2_OFS      8'h10
`define MIN_FIELD_OFS        8'h14
`define FIELD_DEMAND_IN_OFS  8'h18
`define FB_SCALING_OFS       8'h1c
`define STATUS_OFS           8'h20
`define FIRING_OFS           8'h24
`define FIELD_DEMAND_OFS     8'h28
`define GAIN_CODE_OFS        8'h2c

`define ECON_TIMEOUT_RST     8'h1e
`define ENDSTOP_RST          10'h3e8
`define MAX_FIELD_1_RST      10'h3e8
`define MAX_FIELD_2_RST      10'h1f4
`define MIN_FIELD_RST        10'h1f4
`define FB_SCALING_RST       8'h65
`define FB_SCALING_MIN       8'h65
`define FB_SCALING_MAX       8'h6e
`define FIRING_FULL          10'h3e8
`define GAIN_UNITY           16'h0400
`define GAIN_FRAC_BITS       10

// control register bit positions
`define CTL_FIELD_EN         0
`define CTL_SECOND_MAX       1
`define CTL_ECON_EN          2
`define CTL_FIELD_IGAIN      3
`define CTL_VOLT_IGAIN       4
`define CTL_DIRECT_FIRE      5
`define CTL_IR_SRC           6
`define CTL_BRIDGE_FULL      7
`define CTL_REDUCE_TWO       8
`define CTL_REDUCE_FOUR      9
`define CTL_RST              10'h008

`define CLK_HZ               50000000
`define SEC_CYCLES           (`CLK_HZ)
`define AXI_OKAY             2'h0
`define AXI_SLVERR           2'h2

`endif
